// *** sei_pkg.sv ***
package sei_pkg;

  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned T_WR_MS = 4;
  localparam int unsigned T_WR_CYCLES = (T_WR_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  localparam int MEM_DEPTH = 1024;
  localparam int ADDR_W = 10;
  localparam int PAGE_BYTES = 16;
  localparam int IDX_W = 4;

  localparam logic [3:0] TYPE_CODE = 4'hA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  typedef enum logic [1:0] {
    SEI_IDLE,
    SEI_RX,
    SEI_TX,
    SEI_IGN
  } sei_state_t;

  typedef enum logic [1:0] {
    SEI_K_DEV,
    SEI_K_WADDR,
    SEI_K_DATA
  } sei_kind_t;

  typedef struct packed {
    logic [7:0] data;
    logic [IDX_W-1:0] idx;
  } sei_word_t;

endpackage

// *** sei_top.sv ***
// What this block does
// - Acknowledge own target address by pulling data low in the ninth clock.
// - In writes, acknowledge the byte address and every data byte.
// - In reads, send eight bits, release data in the ninth clock, continue on ack.
// - While the internal write runs, release data and ignore all requests.
// - A page write takes up to sixteen bytes, committed in one write cycle.
// - Each written byte is acknowledged and advances only the low four address bits.
// - More than sixteen bytes wrap within the page, overwriting earlier ones.
// - The write cycle starts at stop and stores all buffered bytes together.
// - Write-direction address is not acknowledged while busy, acknowledged after.
// - A high write-protect level blocks all writes; low has no effect.
// - Write protect is sampled at the last falling clock before the first data byte.
// - Sampled protect high refuses the data byte and drops the whole write.
// - Every memory byte starts at all ones.
// - A read-direction address is acknowledged and the current byte sent at once.
// - No acknowledge then stop after a read byte returns to standby.
// - While the controller acknowledges, following bytes keep being sent.
// - Sequential reads advance over the whole memory and wrap to zero.
// - Target address is type code, three extension bits, then the direction bit.
// - Upper extension bit must match the select input; lower two are address bits.
// - Sample data on rising clock, change it on falling clock, drive only low.
`timescale 1ns/1ps
`default_nettype none

module sei_top
  import sei_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = sei_pkg::T_WR_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_address_input,
  input wire logic write_protect_in,
  output logic write_busy
);
  import sei_pkg::*;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic wp1;
    logic wp2;
    logic cs1;
    logic cs2;
    sei_state_t st;
    sei_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [IDX_W-1:0] idx;
    logic wp_q;
    logic wr_pend;
    logic commit_req;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] pmask;
    logic [1:0][$bits(sei_word_t)-1:0] fifo;
    logic fwr;
    logic frd;
    logic [1:0] fcnt;
    logic busy;
    logic [TIMER_W-1:0] timer;
    logic oe;
    logic drv;
    logic [MEM_DEPTH-1:0][7:0] mem;
  } sei_regs_t;

  sei_regs_t s_q;
  sei_regs_t s_d;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic push;
  logic pop;
  logic fifo_ready;
  sei_word_t head;
  sei_word_t in_word;

  localparam logic [TIMER_W-1:0] WR_LAST = TIMER_W'(WRITE_CYCLES - 1);

  always_comb
  begin
    scl_rise = s_q.scl2 & ~s_q.scl3;
    scl_fall = ~s_q.scl2 & s_q.scl3;
    start_cond = s_q.scl2 & s_q.scl3 & s_q.sda3 & ~s_q.sda2;
    stop_cond = s_q.scl2 & s_q.scl3 & ~s_q.sda3 & s_q.sda2;
    fifo_ready = (s_q.fcnt != 2'd2);
    head = sei_word_t'(s_q.fifo[s_q.frd]);
    in_word.data = s_q.shift;
    in_word.idx = s_q.idx;
    push = 1'b0;
    pop = 1'b0;
    s_d = s_q;

    // Input pins pass two flip-flops; edge detection reads only the second stage onward.
    s_d.scl1 = scl_in;
    s_d.scl2 = s_q.scl1;
    s_d.scl3 = s_q.scl2;
    s_d.sda1 = sda_in;
    s_d.sda2 = s_q.sda1;
    s_d.sda3 = s_q.sda2;
    s_d.wp1 = write_protect_in;
    s_d.wp2 = s_q.wp1;
    s_d.cs1 = chip_select_address_input;
    s_d.cs2 = s_q.cs1;
    s_d.drv = 1'b0;

    // The two-entry buffer drains into the page buffer unless a write cycle holds it.
    if (s_q.fcnt != 2'd0 && !s_q.busy)
    begin
      pop = 1'b1;
      s_d.pbuf[head.idx] = head.data;
      s_d.pmask[head.idx] = 1'b1;
      s_d.frd = ~s_q.frd;
    end

    // Commit waits for the buffer to empty, then stores the page in one step.
    if (s_q.commit_req && s_q.fcnt == 2'd0)
    begin
      s_d.commit_req = 1'b0;
      s_d.busy = 1'b1;
      s_d.timer = '0;
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (s_q.pmask[i])
        begin
          s_d.mem[{s_q.addr[ADDR_W-1:IDX_W], IDX_W'(i)}] = s_q.pbuf[i];
        end
      end
      s_d.pmask = '0;
    end

    if (s_q.busy)
    begin
      if (s_q.timer == WR_LAST)
      begin
        s_d.busy = 1'b0;
      end
      else
      begin
        s_d.timer = s_q.timer + 1'b1;
      end
    end

    if (start_cond)
    begin
      s_d.oe = 1'b0;
      s_d.cnt = '0;
      s_d.kind = SEI_K_DEV;
      s_d.wr_pend = 1'b0;
      s_d.pmask = s_q.commit_req ? s_q.pmask : '0;
      if (s_q.busy || s_q.commit_req)
      begin
        s_d.st = SEI_IGN;
      end
      else
      begin
        s_d.st = SEI_RX;
      end
    end
    else if (stop_cond)
    begin
      s_d.oe = 1'b0;
      s_d.st = SEI_IDLE;
      if (s_q.wr_pend && !s_q.wp_q)
      begin
        s_d.commit_req = 1'b1;
      end
      s_d.wr_pend = 1'b0;
    end
    else
    begin
      unique case (s_q.st)
        SEI_IDLE, SEI_IGN:
        begin
          s_d.oe = 1'b0;
        end
        SEI_RX:
        begin
          if (scl_rise && s_q.cnt < BITS_PER_BYTE)
          begin
            s_d.shift = {s_q.shift[6:0], s_q.sda2};
            s_d.cnt = s_q.cnt + 1'b1;
          end
          else if (scl_fall && s_q.cnt == BITS_PER_BYTE)
          begin
            s_d.cnt = ACK_SLOT;
            unique case (s_q.kind)
              SEI_K_DEV:
              begin
                if (s_q.shift[7:4] == TYPE_CODE && s_q.shift[3] == s_q.cs2)
                begin
                  s_d.oe = 1'b1;
                  s_d.rw = s_q.shift[0];
                  s_d.addr[ADDR_W-1:8] = s_q.shift[2:1];
                end
                else
                begin
                  s_d.st = SEI_IGN;
                end
              end
              SEI_K_WADDR:
              begin
                s_d.oe = 1'b1;
                s_d.addr[7:0] = s_q.shift;
                s_d.idx = s_q.shift[3:0];
              end
              default:
              begin
                if (s_q.wp_q)
                begin
                  s_d.wr_pend = 1'b0;
                  s_d.pmask = '0;
                  s_d.st = SEI_IGN;
                end
                else if (fifo_ready)
                begin
                  push = 1'b1;
                  s_d.oe = 1'b1;
                  s_d.wr_pend = 1'b1;
                  s_d.idx = s_q.idx + 1'b1;
                  s_d.addr[IDX_W-1:0] = s_q.idx + 1'b1;
                end
                else
                begin
                  s_d.st = SEI_IGN;
                end
              end
            endcase
          end
          else if (scl_fall && s_q.cnt == ACK_SLOT)
          begin
            s_d.oe = 1'b0;
            s_d.cnt = '0;
            unique case (s_q.kind)
              SEI_K_DEV:
              begin
                if (s_q.rw)
                begin
                  s_d.st = SEI_TX;
                  s_d.shift = s_q.mem[s_q.addr];
                  s_d.oe = ~s_q.mem[s_q.addr][7];
                end
                else
                begin
                  s_d.kind = SEI_K_WADDR;
                end
              end
              SEI_K_WADDR:
              begin
                s_d.kind = SEI_K_DATA;
                s_d.wp_q = s_q.wp2;
              end
              default:
              begin
                s_d.kind = SEI_K_DATA;
              end
            endcase
          end
        end
        SEI_TX:
        begin
          if (scl_fall && s_q.cnt < BITS_PER_BYTE)
          begin
            s_d.cnt = s_q.cnt + 1'b1;
            s_d.shift = {s_q.shift[6:0], 1'b1};
            s_d.oe = (s_q.cnt == 4'd7) ? 1'b0 : ~s_q.shift[6];
          end
          else if (scl_rise && s_q.cnt == BITS_PER_BYTE)
          begin
            s_d.addr = s_q.addr + 1'b1;
            if (s_q.sda2)
            begin
              s_d.st = SEI_IGN;
            end
            else
            begin
              s_d.cnt = ACK_SLOT;
            end
          end
          else if (scl_fall && s_q.cnt == ACK_SLOT)
          begin
            s_d.cnt = '0;
            s_d.shift = s_q.mem[s_q.addr];
            s_d.oe = ~s_q.mem[s_q.addr][7];
          end
        end
      endcase
    end

    if (push)
    begin
      s_d.fifo[s_q.fwr] = in_word;
      s_d.fwr = ~s_q.fwr;
    end
    s_d.fcnt = s_q.fcnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.scl1 <= 1'b1;
      s_q.scl2 <= 1'b1;
      s_q.scl3 <= 1'b1;
      s_q.sda1 <= 1'b1;
      s_q.sda2 <= 1'b1;
      s_q.sda3 <= 1'b1;
      s_q.st <= SEI_IDLE;
      s_q.kind <= SEI_K_DEV;
      s_q.mem <= {MEM_DEPTH{ERASED_BYTE}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sda_out = s_q.drv;
  assign sda_oe = s_q.oe;
  assign write_busy = s_q.busy;

endmodule

`default_nettype wire

// *** sei_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sei_asserts #(
  parameter int unsigned WRITE_CYCLES = 200
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_select_address_input,
  input wire logic write_protect_in,
  input wire logic write_busy
);
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  always_comb cnt_d = write_busy ? cnt_q + 20'h00001 : 20'h00000;
  always_ff @(posedge clock) cnt_q <= rst_n ? cnt_d : 20'h00000;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_drive_only_low: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  a_busy_released: assert property (write_busy |-> !sda_oe)
    else $error("data driven while busy");
  a_change_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed with clock high");
  a_hold_clock_high: assert property ($rose(scl_in) |-> ##1 $stable(sda_oe)[*6])
    else $error("data not held in high phase");
  a_drive_before_rise: assert property ($rose(sda_oe) |-> ##[1:14] $rose(scl_in))
    else $error("drive not ahead of clock rise");
  a_commit_at_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
    else $error("write began outside stop");
  a_busy_steady: assert property ($rose(write_busy) |=> write_busy[*8])
    else $error("write cycle cut short");
  a_busy_length: assert property ($fell(write_busy) |-> cnt_q == 20'(WRITE_CYCLES))
    else $error("write cycle length wrong");
endmodule
bind sei_top sei_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) sei_asserts_inst (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .chip_select_address_input(chip_select_address_input),
  .write_protect_in(write_protect_in), .write_busy(write_busy));
`default_nettype wire

// *** sei_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
module sei_ctl (
  input wire logic clock,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic s;
  assign scl = scl_q;
  // Pulled-up wire: low when either party pulls it.
  assign sda = sda_q & ~(sda_oe & ~sda_out);
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl_q <= 1'b0;
    wt(4);
    sda_q <= b;
    wt(4);
    scl_q <= 1'b1;
    wt(4);
    r = sda;
    wt(4);
  endtask
  task automatic start();
    scl_q <= 1'b0;
    wt(4);
    sda_q <= 1'b1;
    wt(4);
    scl_q <= 1'b1;
    wt(8);
    sda_q <= 1'b0;
    wt(8);
  endtask
  task automatic stop();
    scl_q <= 1'b0;
    wt(4);
    sda_q <= 1'b0;
    wt(4);
    scl_q <= 1'b1;
    wt(8);
    sda_q <= 1'b1;
    wt(8);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, s);
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  logic wp = 1'b0;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic busy;
  logic a;
  logic [7:0] b;
  int bad_count = 0;
  int comparisons = 0;
  initial forever #2.5 clock = ~clock;
  sei_top #(.WRITE_CYCLES(200)) sei_top_inst (.clock(clock), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_address_input(sel),
    .write_protect_in(wp), .write_busy(busy));
  sei_ctl sei_ctl_inst (.clock(clock), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %0t saw %h wanted %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tx(input logic [7:0] d, input logic e);
    sei_ctl_inst.send(d, a);
    chk({7'h00, a}, {7'h00, e});
  endtask
  task automatic rd(input logic [7:0] e, input logic k);
    sei_ctl_inst.recv(k, b);
    chk(b, e);
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk({5'h00, sda_out, sda_oe, busy}, 8'h00);
    sei_ctl_inst.start();
    tx(8'hA9, 1'b1);
    rd(8'hFF, 1'b0);
    sei_ctl_inst.stop();
    sei_ctl_inst.start();
    tx(8'hA0, 1'b0);
    sei_ctl_inst.start();
    tx(8'hB8, 1'b0);
    sei_ctl_inst.stop();
    sei_ctl_inst.start();
    tx(8'hAE, 1'b1);
    tx(8'hFE, 1'b1);
    for (int i = 0; i < 18; i++) tx(8'h10 + 8'(i), 1'b1);
    sei_ctl_inst.stop();
    chk({7'h00, busy}, 8'h01);
    sei_ctl_inst.start();
    tx(8'hAE, 1'b0);
    sei_ctl_inst.stop();
    a = 1'b0;
    for (int i = 0; i < 20 && !a; i++)
    begin
      sei_ctl_inst.start();
      sei_ctl_inst.send(8'hAE, a);
      if (!a) sei_ctl_inst.stop();
    end
    if (!a)
    begin
      bad_count++;
      stop_test();
    end
    tx(8'hF0, 1'b1);
    sei_ctl_inst.start();
    tx(8'hAF, 1'b1);
    for (int k = 0; k < 17; k++) rd(k < 16 ? 8'h12 + 8'(k) : 8'hFF, k < 16);
    sei_ctl_inst.stop();
    // Protect rises only after the strobe point, so this byte must still be written.
    sei_ctl_inst.start();
    tx(8'hAE, 1'b1);
    tx(8'hF1, 1'b1);
    fork
      tx(8'h66, 1'b1);
      begin
        sei_ctl_inst.wt(20);
        wp <= 1'b1;
      end
    join
    sei_ctl_inst.stop();
    chk({7'h00, busy}, 8'h01);
    sei_ctl_inst.wt(220);
    wp <= 1'b1;
    sei_ctl_inst.start();
    tx(8'hAE, 1'b1);
    tx(8'hF0, 1'b1);
    tx(8'h55, 1'b0);
    sei_ctl_inst.stop();
    wp <= 1'b0;
    sei_ctl_inst.wt(20);
    chk({7'h00, busy}, 8'h00);
    sei_ctl_inst.start();
    tx(8'hAE, 1'b1);
    tx(8'hF0, 1'b1);
    sei_ctl_inst.start();
    tx(8'hAF, 1'b1);
    rd(8'h12, 1'b1);
    rd(8'h66, 1'b0);
    sei_ctl_inst.stop();
    stop_test();
  end
endmodule
`default_nettype wire
